// ### hw/tcef_top.sv
// Timer channel event flags with counter, APB registers and interrupt
//
// How it works
// - Each channel flag meaning follows that channel's current mode.
// - Capture edge select: off, rising, falling or either edge.
// - Capture mode sets the flag on each selected edge of the input.
// - Compare mode sets the flag whenever the running counter equals the channel value.
// - Edge PWM sets the flag at the counter match ending the duty.
// - Center PWM sets the flag at both matches, up and down.
// - Flags clear only through the read-then-write-zero sequence.
// - An event between the read and the write keeps the flag set.
// - Channel interrupt is high while flag and its enable are both set.
// - Center PWM counter counts up to a nonzero modulus then down to zero.
//
// Register map: CTRL 0x00, MOD 0x04, CNT 0x08 read only, STAT 0x0c, MASK 0x10;
// channel n has CTRL at 0x20 + 8n and VAL at 0x24 + 8n.
// Every transfer completes without a wait state; unmapped addresses answer with an error.
`timescale 1ns/1ns
module tcef_top
  import tcef_pkg::*;
(
  input  wire logic                         pclk,      // Timer and bus clock
  input  wire logic                         presetn,   // Asynchronous reset, active low
  input  wire logic [tcef_pkg::TCEF_ADDR_W-1:0] paddr, // APB byte address
  input  wire logic                         psel,      // APB select
  input  wire logic                         penable,   // APB access phase
  input  wire logic                         pwrite,    // APB write
  input  wire logic [31:0]                  pwdata,    // APB write data
  output logic      [31:0]                  prdata,    // APB read data
  output logic                              pready,    // APB ready
  output logic                              pslverr,   // APB error, unmapped address
  input  wire logic [tcef_pkg::TCEF_NCH-1:0] chan_in,  // Channel pins, asynchronous
  output logic      [tcef_pkg::TCEF_NCH-1:0] chan_irq, // Per-channel level interrupts
  output logic                              irq        // Masked status interrupt
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                 run_q;
  logic                 center_pwm_select_q;
  logic [15:0]          mod_q;
  logic [15:0]          cnt;
  logic                 ovf;
  logic [TCEF_STAT_W-1:0] stat_q;
  logic [TCEF_STAT_W-1:0] stat_d;
  logic [TCEF_STAT_W-1:0] mask_q;
  logic [TCEF_STAT_W-1:0] ev_bits;
  logic                 setup;
  logic                 access;
  logic                 wr_acc;
  logic                 rd_acc;
  logic                 sel_ctrl;
  logic                 sel_mod;
  logic                 sel_cnt;
  logic                 sel_stat;
  logic                 sel_mask;
  logic [TCEF_NCH-1:0]  sel_chctrl;
  logic [TCEF_NCH-1:0]  sel_chval;
  logic                 mapped;
  logic [31:0]          rd_glob;
  logic [31:0]          rd_mux;
  logic [31:0]          ch_rd     [TCEF_NCH];
  logic [TCEF_NCH-1:0]  ch_event;
  logic [TCEF_NCH-1:0]  ch_flag_d;
  logic [TCEF_NCH-1:0]  ch_ien_d;
  logic [TCEF_STAT_W-1:0] stat_clr;
  logic [TCEF_STAT_W-1:0] mask_d;
  logic                 irq_d;
  logic [TCEF_NCH-1:0]  chan_irq_d;

  // ----------------------------------------------------------------
  // APB phase decode
  // ----------------------------------------------------------------

  // Setup cycle prepares the answer, access cycle commits it
  assign setup  = psel && !penable;
  assign access = psel && penable && pready;
  assign wr_acc = access && pwrite;
  assign rd_acc = access && !pwrite;

  // Global register address decode
  assign sel_ctrl = (paddr == TCEF_OFF_CTRL);
  assign sel_mod  = (paddr == TCEF_OFF_MOD);
  assign sel_cnt  = (paddr == TCEF_OFF_CNT);
  assign sel_stat = (paddr == TCEF_OFF_STAT);
  assign sel_mask = (paddr == TCEF_OFF_MASK);
  assign mapped   = sel_ctrl || sel_mod || sel_cnt || sel_stat || sel_mask ||
                    (|sel_chctrl) || (|sel_chval);

  // Read data of the global registers
  assign rd_glob = sel_ctrl ? {30'h0, center_pwm_select_q, run_q} :
                   sel_mod  ? {16'h0, mod_q} :
                   sel_cnt  ? {16'h0, cnt} :
                   sel_stat ? {29'h0, stat_q} :
                   sel_mask ? {29'h0, mask_q} : 32'h0000_0000;

  // Merge channel read data; only one select is ever active
  always_comb begin
    rd_mux = rd_glob;
    for (int k = 0; k < TCEF_NCH; k++) begin
      rd_mux = rd_mux | ch_rd[k];
    end
  end

  // ----------------------------------------------------------------
  // APB answer registers
  // ----------------------------------------------------------------

  // No wait state: answer is registered in the setup cycle
  // An unmapped address raises pslverr and its write is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      prdata  <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Global control registers
  // ----------------------------------------------------------------

  // Counter enable and center mode select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q               <= 1'b0;
      center_pwm_select_q <= 1'b0;
    end else if (wr_acc && sel_ctrl) begin
      run_q               <= pwdata[TCEF_CTRL_EN_BIT];
      center_pwm_select_q <= pwdata[TCEF_CTRL_CPWM_BIT];
    end
  end

  // Modulus; a new value takes effect at once, there is no buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_q <= TCEF_RST_MOD;
    end else if (wr_acc && sel_mod) begin
      mod_q <= pwdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Main counter
  // ----------------------------------------------------------------
  // Counter steps every clock while run is set; the channels only compare or capture
  tcef_counter i_tcef_counter (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (run_q),
    .center  (center_pwm_select_q),
    .modulus (mod_q),
    .cnt_q   (cnt),
    .ovf     (ovf)
  );

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  for (genvar i = 0; i < TCEF_NCH; i++) begin : g_ch

    localparam logic [7:0] A_CTRL = TCEF_OFF_CH0_CTRL + TCEF_CH_STRIDE * 8'(i);
    localparam logic [7:0] A_VAL  = TCEF_OFF_CH0_VAL  + TCEF_CH_STRIDE * 8'(i);

    tcef_chcfg_t cfg_q;
    tcef_mode_t  mode;
    logic [15:0] val_q;
    logic        flag_q;
    logic        flag_d;
    logic        armed_q;
    logic        armed_d;
    logic        pin_s;
    logic        pin_prev_q;
    logic        rise;
    logic        fall;
    logic        cap_hit;
    logic        match;
    logic        cmp_hit;
    logic        set_ev;
    logic        rd_flag;
    logic        wr_zero;
    logic        clr;

    // Channel register decode
    assign sel_chctrl[i] = (paddr == A_CTRL);
    assign sel_chval[i]  = (paddr == A_VAL);

    // Channel pin into the timer clock domain
    tcef_sync i_tcef_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (chan_in[i]),
      .dout    (pin_s)
    );

    // Previous synchronised level for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pin_prev_q <= 1'b0;
      end else begin
        pin_prev_q <= pin_s;
      end
    end

    // Mode decode: center select overrides every channel
    // Codes 2 and 3 of the mode field both give edge PWM
    assign mode = center_pwm_select_q                     ? TCEF_MODE_CPWM :
                  (cfg_q.mode_sel == TCEF_MSEL_CAPTURE)   ? TCEF_MODE_CAPTURE :
                  (cfg_q.mode_sel == TCEF_MSEL_COMPARE)   ? TCEF_MODE_COMPARE :
                                                            TCEF_MODE_EPWM;

    // Edge qualification by the edge select pair
    assign rise    = pin_s && !pin_prev_q;
    assign fall    = !pin_s && pin_prev_q;
    assign cap_hit = (cfg_q.edge_level_select_low  && rise) ||
                     (cfg_q.edge_level_select_high && fall);

    // Counter match, only while the counter steps
    // A stopped counter would otherwise match on every cycle
    assign match = run_q && (cnt == val_q);

    // Match events by mode; center mode passes each value up and down
    always_comb begin
      cmp_hit = 1'b0;
      case (mode)
        TCEF_MODE_CAPTURE: cmp_hit = 1'b0;
        TCEF_MODE_COMPARE: cmp_hit = match;
        TCEF_MODE_EPWM:    cmp_hit = match;
        TCEF_MODE_CPWM:    cmp_hit = match;
        default:           cmp_hit = 1'b0;
      endcase
    end

    // Flag set source
    assign set_ev = (mode == TCEF_MODE_CAPTURE) ? cap_hit : cmp_hit;

    // Two-step clear: a read that reported the flag set arms, write of zero clears
    // The reported bit is the registered read data, so a flag that rises
    // between setup and access never arms a clear that software did not see
    assign rd_flag = rd_acc && sel_chctrl[i] && prdata[TCEF_CH_FLAG_BIT];
    assign wr_zero = wr_acc && sel_chctrl[i] && !pwdata[TCEF_CH_FLAG_BIT];
    assign clr     = wr_zero && armed_q;

    // New event beats the clear and restarts the sequence
    assign flag_d  = set_ev || (flag_q && !clr);
    assign armed_d = set_ev                              ? 1'b0 :
                     rd_flag                             ? 1'b1 :
                     (wr_acc && sel_chctrl[i])           ? 1'b0 : armed_q;

    // Flag and clear sequence state
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        flag_q  <= 1'b0;
        armed_q <= 1'b0;
      end else begin
        flag_q  <= flag_d;
        armed_q <= armed_d;
      end
    end

    // Channel configuration register
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cfg_q <= TCEF_RST_CHCFG;
      end else if (wr_acc && sel_chctrl[i]) begin
        cfg_q.mode_sel               <= pwdata[TCEF_CH_MODE_LSB +: 2];
        cfg_q.edge_level_select_low  <= pwdata[TCEF_CH_ELSL_BIT];
        cfg_q.edge_level_select_high <= pwdata[TCEF_CH_ELSH_BIT];
        cfg_q.channel_irq_enable     <= pwdata[TCEF_CH_IEN_BIT];
      end
    end

    // Channel value: capture of the counter wins over a bus write
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        val_q <= TCEF_RST_VAL;
      end else if ((mode == TCEF_MODE_CAPTURE) && cap_hit) begin
        val_q <= cnt;
      end else if (wr_acc && sel_chval[i]) begin
        val_q <= pwdata[15:0];
      end
    end

    // Channel read data
    assign ch_rd[i] = sel_chctrl[i] ? {24'h0, flag_q, 2'h0, cfg_q.channel_irq_enable,
                                       cfg_q.edge_level_select_high,
                                       cfg_q.edge_level_select_low, cfg_q.mode_sel} :
                      sel_chval[i]  ? {16'h0, val_q} : 32'h0000_0000;

    // Outputs towards the interrupt logic
    assign ch_event[i]  = set_ev;
    assign ch_flag_d[i] = flag_d;
    assign ch_ien_d[i]  = (wr_acc && sel_chctrl[i]) ? pwdata[TCEF_CH_IEN_BIT] :
                                                      cfg_q.channel_irq_enable;
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------

  // Sticky events; set wins over the read clear
  assign ev_bits = {ovf, ch_event};

  // A status read clears only the bits that it reported, so an event
  // landing between the setup and the access cycle is kept
  assign stat_clr = (rd_acc && sel_stat) ? prdata[TCEF_STAT_W-1:0] : '0;
  assign stat_d   = ev_bits | (stat_q & ~stat_clr);

  // Mask as it stands after this edge
  assign mask_d = (wr_acc && sel_mask) ? pwdata[TCEF_STAT_W-1:0] : mask_q;

  // Interrupt levels from next state, so they move with status and flags
  assign irq_d      = |(stat_d & mask_d);
  assign chan_irq_d = ch_flag_d & ch_ien_d;

  // Status and mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= TCEF_RST_STAT;
      mask_q <= TCEF_RST_MASK;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
    end
  end

  // Interrupt outputs, straight from flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq      <= 1'b0;
      chan_irq <= '0;
    end else begin
      irq      <= irq_d;
      chan_irq <= chan_irq_d;
    end
  end

endmodule : tcef_top

// ### hw/tcef_pkg.sv
// Package of constants and types for the timer channel event flag block
package tcef_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned TCEF_NCH       = 2;
  localparam int unsigned TCEF_CNT_W     = 16;
  localparam int unsigned TCEF_ADDR_W    = 8;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TCEF_OFF_CTRL      = 8'h00;
  localparam logic [7:0] TCEF_OFF_MOD       = 8'h04;
  localparam logic [7:0] TCEF_OFF_CNT       = 8'h08;
  localparam logic [7:0] TCEF_OFF_STAT      = 8'h0c;
  localparam logic [7:0] TCEF_OFF_MASK      = 8'h10;
  localparam logic [7:0] TCEF_OFF_CH0_CTRL  = 8'h20;
  localparam logic [7:0] TCEF_OFF_CH0_VAL   = 8'h24;
  localparam logic [7:0] TCEF_CH_STRIDE     = 8'h08;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned TCEF_CTRL_EN_BIT   = 0;
  localparam int unsigned TCEF_CTRL_CPWM_BIT = 1;
  localparam int unsigned TCEF_CH_MODE_LSB   = 0;
  localparam int unsigned TCEF_CH_ELSL_BIT   = 2;
  localparam int unsigned TCEF_CH_ELSH_BIT   = 3;
  localparam int unsigned TCEF_CH_IEN_BIT    = 4;
  localparam int unsigned TCEF_CH_FLAG_BIT   = 7;
  localparam int unsigned TCEF_STAT_OVF_BIT  = 2;
  localparam int unsigned TCEF_STAT_W        = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] TCEF_RST_MOD  = 16'h0000;
  localparam logic [15:0] TCEF_RST_VAL  = 16'h0000;
  localparam logic [15:0] TCEF_RST_CNT  = 16'h0000;
  localparam logic [2:0]  TCEF_RST_STAT = 3'h0;
  localparam logic [2:0]  TCEF_RST_MASK = 3'h0;

  // ----------------------------------------------------------------
  // Channel mode select field codes
  // ----------------------------------------------------------------
  localparam logic [1:0] TCEF_MSEL_CAPTURE = 2'h0;
  localparam logic [1:0] TCEF_MSEL_COMPARE = 2'h1;

  // Decoded channel mode, one-hot
  typedef enum logic [3:0] {
    TCEF_MODE_CAPTURE = 4'b0001,
    TCEF_MODE_COMPARE = 4'b0010,
    TCEF_MODE_EPWM    = 4'b0100,
    TCEF_MODE_CPWM    = 4'b1000
  } tcef_mode_t;

  // Per-channel software configuration
  typedef struct packed {
    logic [1:0] mode_sel;
    logic       edge_level_select_high;
    logic       edge_level_select_low;
    logic       channel_irq_enable;
  } tcef_chcfg_t;

  localparam tcef_chcfg_t TCEF_RST_CHCFG = '{2'h0, 1'b0, 1'b0, 1'b0};

endpackage : tcef_pkg

// ### hw/tcef_sync.sv
// Two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ns
module tcef_sync (
  input  wire logic pclk,     // Timer clock
  input  wire logic presetn,  // Asynchronous reset, active low
  input  wire logic din,      // Asynchronous level
  output logic      dout      // Synchronised level
);

  logic meta_q;

  // Second stage is the only reader of the first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule : tcef_sync

// ### hw/tcef_counter.sv
// Main 16-bit timer counter, up or up/down counting
`timescale 1ns/1ns
module tcef_counter
  import tcef_pkg::*;
(
  input  wire logic        pclk,     // Timer clock
  input  wire logic        presetn,  // Asynchronous reset, active low
  input  wire logic        run,      // Counter enable
  input  wire logic        center,   // Up/down counting
  input  wire logic [15:0] modulus,  // Terminal count, zero runs free
  output logic      [15:0] cnt_q,    // Counter value
  output logic             ovf       // One-cycle overflow pulse
);

  logic        down_q;
  logic [15:0] cnt_d;
  logic        down_d;
  logic        at_mod;
  logic        at_top;

  // Terminal count: modulus, or all ones when modulus is zero
  assign at_mod = (modulus != 16'h0000) && (cnt_q == modulus);
  assign at_top = at_mod || ((modulus == 16'h0000) && (cnt_q == 16'hffff));

  // Next count and direction
  always_comb begin
    cnt_d  = cnt_q;
    down_d = down_q;
    ovf    = 1'b0;
    if (run) begin
      if (center) begin
        if (!down_q && at_mod) begin
          down_d = 1'b1;
          cnt_d  = cnt_q - 16'h0001;
          ovf    = 1'b1;
        end else if (down_q && (cnt_q == 16'h0000)) begin
          down_d = 1'b0;
          cnt_d  = 16'h0001;
        end else if (down_q) begin
          cnt_d = cnt_q - 16'h0001;
        end else begin
          cnt_d = cnt_q + 16'h0001;
        end
      end else begin
        down_d = 1'b0;
        ovf    = at_top;
        cnt_d  = at_top ? 16'h0000 : cnt_q + 16'h0001;
      end
    end
  end

  // Counter state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= TCEF_RST_CNT;
      down_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      down_q <= down_d;
    end
  end

endmodule : tcef_counter

// ### sim/tcef_chk.sv
// Concurrent checks on the ports of the timer channel event flag block
`timescale 1ns/1ns
module tcef_chk (
  input wire logic        pclk,     // Clock
  input wire logic        presetn,  // Reset, active low
  input wire logic [7:0]  paddr,    // APB address
  input wire logic        psel,     // APB select
  input wire logic        penable,  // APB access phase
  input wire logic        pwrite,   // APB write
  input wire logic [31:0] pwdata,   // APB write data
  input wire logic [31:0] prdata,   // APB read data
  input wire logic        pready,   // APB ready
  input wire logic        pslverr,  // APB error
  input wire logic [1:0]  chan_in,  // Channel pins
  input wire logic [1:0]  chan_irq, // Channel interrupts
  input wire logic        irq       // Status interrupt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // Decodes
  // ----------------------------------------------------------------
  // Setup cycle and mapped address
  wire setup = psel && !penable;
  wire mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20, 8'h24, 8'h28, 8'h2c};

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  a_ready_after_setup: assert property (setup |=> pready && psel && penable)
    else $error("ready missing after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside an access");
  a_err_unmapped: assert property (setup && !mapped |=> pslverr)
    else $error("no error on unmapped address");
  a_err_mapped: assert property (setup && mapped |=> !pslverr)
    else $error("error on mapped address");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero when idle");
  a_err_rdata: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("read data on refused read");

  // ----------------------------------------------------------------
  // Flag and interrupt clearing
  // ----------------------------------------------------------------
  a_chirq0_clear: assert property ($fell(chan_irq[0]) |->
      $past(pready && pwrite && paddr == 8'h20))
    else $error("channel 0 interrupt fell without a write");
  a_chirq1_clear: assert property ($fell(chan_irq[1]) |->
      $past(pready && pwrite && paddr == 8'h28))
    else $error("channel 1 interrupt fell without a write");
  a_irq_clear: assert property ($fell(irq) |->
      $past(pready && (paddr == 8'h0c && !pwrite || paddr == 8'h10 && pwrite)))
    else $error("interrupt fell without status read or mask write");

  // Main scenarios
  c_unmapped: cover property (setup && !mapped);
  c_chirq1_fell: cover property ($fell(chan_irq[1]));
  c_irq_rose: cover property ($rose(irq));
endmodule : tcef_chk

// ### sim/tcef_pin_model.sv
// Model of the external source that drives the channel pins
`timescale 1ns/1ns
module tcef_pin_model (
  input  wire logic [1:0] lvl,     // Requested pin levels
  output logic      [1:0] chan_in  // Pin levels
);
  // Pins move 7 ns after a request, unrelated to the sampling edge
  initial chan_in = 2'h0;
  always @(lvl) chan_in <= #7 lvl;
endmodule : tcef_pin_model

// ### sim/tcef_top_test.sv
// Self-checking bench for the timer channel event flag block
`timescale 1ns/1ns
module tcef_top_test;
  import tcef_pkg::*;
  logic        pclk     = 1'b0;
  logic        presetn  = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [31:0] pwdata   = 32'h0;
  logic [1:0]  pin_lvl  = 2'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  chan_in;
  logic [1:0]  chan_irq;
  logic        irq;
  logic [31:0] rd;
  logic        er;
  int          n_errors = 0;
  int          comparisons = 0;
  int          t[3];

  // ----------------------------------------------------------------
  // Clock, design and pin source
  // ----------------------------------------------------------------
  always #10 pclk = ~pclk;

  tcef_top i_tcef_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chan_in(chan_in), .chan_irq(chan_irq), .irq(irq));
  tcef_pin_model i_tcef_pin_model (.lvl(pin_lvl), .chan_in(chan_in));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (n >= 20) chk(32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask : rchk

  function automatic logic [7:0] cc(input int c);
    return TCEF_OFF_CH0_CTRL + 8'(c) * TCEF_CH_STRIDE;
  endfunction : cc

  // Read while set, then write zero
  task automatic clr(input int c, input logic [31:0] cfg);
    apb(1'b0, cc(c), 32'h0);
    apb(1'b1, cc(c), cfg);
  endtask : clr

  task automatic pin(input int c, input logic v);
    pin_lvl[c] <= v;
    repeat (6) @(posedge pclk);
  endtask : pin

  // Time three channel 1 events, clearing each, and check the spacing
  task automatic gaps(input logic [31:0] ctl, input logic [31:0] cfg, input int a, input int b);
    apb(1'b1, TCEF_OFF_CTRL, 32'h0);
    apb(1'b1, cc(1) + 8'h04, 32'd5);
    apb(1'b1, TCEF_OFF_MOD, 32'd12);
    clr(1, cfg);
    apb(1'b1, TCEF_OFF_CTRL, ctl);
    for (int k = 0; k < 3; k++) begin
      int n;
      n = 0;
      while (chan_irq[1] !== 1'b1 && n < 100) begin
        @(posedge pclk);
        n++;
      end
      if (n >= 100) chk(32'h0, 32'h1);
      t[k] = int'($time / 20);
      clr(1, cfg);
    end
    chk(32'(t[1] - t[0] == a || t[1] - t[0] == b), 32'h1);
    chk(32'(t[2] - t[0]), 32'(a + b));
  endtask : gaps

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values, read-only counter, unmapped place
    chk(32'({chan_irq, irq}), 32'h0);
    rchk(TCEF_OFF_STAT, 32'hffffffff, 32'h0);
    rchk(TCEF_OFF_MASK, 32'hffffffff, 32'h0);
    rchk(TCEF_OFF_MOD, 32'hffffffff, 32'h0);
    rchk(cc(0), 32'hffffffff, 32'h0);
    apb(1'b1, TCEF_OFF_CNT, 32'h0000ffff);
    rchk(TCEF_OFF_CNT, 32'hffffffff, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
    // Every edge select code, rising then falling edge
    for (int es = 0; es < 4; es++) begin
      apb(1'b1, cc(0), 32'(es << 2) | 32'h10);
      pin(0, 1'b1);
      rchk(cc(0), 32'h80, 32'(es & 1) << 7);
      chk(32'(chan_irq[0]), 32'(es & 1));
      clr(0, 32'(es << 2) | 32'h10);
      pin(0, 1'b0);
      rchk(cc(0), 32'h80, 32'((es >> 1) & 1) << 7);
      clr(0, 32'(es << 2) | 32'h10);
      chk(32'(chan_irq[0]), 32'h0);
    end
    // Write zero without a read, and an event between read and write
    apb(1'b1, cc(0), 32'h04);
    pin(0, 1'b1);
    apb(1'b1, cc(0), 32'h04);
    rchk(cc(0), 32'h80, 32'h80);
    pin(0, 1'b0);
    pin(0, 1'b1);
    apb(1'b1, cc(0), 32'h04);
    rchk(cc(0), 32'h80, 32'h80);
    apb(1'b1, cc(0), 32'h04);
    rchk(cc(0), 32'h80, 32'h00);
    // Status, mask and the shared interrupt
    apb(1'b1, TCEF_OFF_MASK, 32'h1);
    pin(0, 1'b0);
    pin(0, 1'b1);
    chk(32'(irq), 32'h1);
    rchk(TCEF_OFF_STAT, 32'h3, 32'h1);
    chk(32'(irq), 32'h0);
    rchk(TCEF_OFF_STAT, 32'h3, 32'h0);
    apb(1'b1, TCEF_OFF_MASK, 32'h0);
    pin(0, 1'b0);
    pin(0, 1'b1);
    chk(32'(irq), 32'h0);
    rchk(TCEF_OFF_STAT, 32'h3, 32'h1);
    // Match events in every counting mode
    gaps(32'h1, 32'h11, 13, 13);
    gaps(32'h1, 32'h12, 13, 13);
    gaps(32'h1, 32'h13, 13, 13);
    gaps(32'h3, 32'h10, 10, 14);
    rchk(TCEF_OFF_STAT, 32'h7, 32'h7);
    stop_test();
  end

  // Watchdog against a hang
  initial begin
    #400000;
    n_errors++;
    stop_test();
  end
endmodule : tcef_top_test

bind tcef_top tcef_chk i_tcef_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .chan_in(chan_in), .chan_irq(chan_irq), .irq(irq));
